// File: common/swb_consts.vh
// Constants for the serial write buffer.
// What this block does
// RULE1 - Runs only when enabled and port outputs
// RULE2 - Two-bit field selects serial clock source
// RULE3 - Data changes on clock rise, sampled falling
// RULE4 - Flag shows finished or buffer empty
// RULE5 - Halt starts automatic send, CPU stays standby
// RULE6 - Automatic end leaves standby, flag goes high
// RULE7 - Last package gets one to four clocks
// RULE8 - Field 00 four, 01 three, 10 two, 11 one
// RULE9 - Automatic mode holds last bit while enabled
// RULE10 - Select 00 automatic uses divided external input
// RULE11 - Undivided external starts third rise, second fall; code starts on the 2nd active edge
// RULE12 - Divided external starts 4th, 46th, 178th clock; code starts on the 2nd, 44th, 176th active edge
// RULE13 - Software loads first nibble, rest from RAM
// RULE14 - Size is last RAM address, 2..64 packages; code sends size plus 2, up to 65
// RULE15 - Auto-send write masks global interrupt enable
// RULE16 - Completion clears auto bit, flag until write
// RULE17 - Halt end restores interrupt enable, CPU resumes
// RULE18 - Start bit loads shifter, empty raises request
// RULE19 - Underrun stops clock low, clears start, request
// RULE20 - Buffer write clears request and flag
// RULE21 - Requests repeat until last bits, start clears
// RULE22 - Interactive always four clocks, no hold
// RULE23 - Resend by rewriting buffer, size, then halt
// RULE24 - Select codes give 9375, 2344, 75000, 150000 Hz
// RULE25 - Bit 0 shifted out first
`ifndef SWB_CONSTS_VH
`define SWB_CONSTS_VH
`define CLK_HZ          20000000
`define RATE_SEL0_HZ    9375
`define RATE_SEL1_HZ    2344
`define RATE_SEL2_HZ    75000
`define RATE_SEL3_HZ    150000
`define HALF_DIV(f)     ((`CLK_HZ / (2 * (f))))
`define SEL_EXT         2'h0
`define SEL_SLOW        2'h1
`define SEL_MID         2'h2
`define SEL_FAST        2'h3
`define EXT_DIV1        2'h0
`define EXT_DIV4        2'h1
`define EXT_DIV88       2'h2
`define EXT_DIV352      2'h3
`define EXT_START1_RISE 3
`define EXT_START1_FALL 2
`define EXT_START4      4
`define EXT_START88     46
`define EXT_START352    178
`define BUF_RESET       4'hF
`define RAM_WORDS       64
`endif

// File: verilog/swb_clk_gen.v
// Serial bit-tick generator for the write buffer.
`timescale 1ns/1ps
`include "swb_consts.vh"
module swb_clk_gen (
  input  wire       core_clk,
  input  wire       rst,
  input  wire       run,
  input  wire       auto_mode,
  input  wire [1:0] serial_clk_select,
  input  wire [1:0] ext_clk_divider,
  input  wire       ext_clk_in,
  input  wire       ext_clk_inverted,
  output reg        rise_tick,
  output reg        fall_tick
);
  // The slowest rate needs a 13-bit half-period count.
  localparam integer H0_I = `HALF_DIV(`RATE_SEL0_HZ);
  localparam integer H1_I = `HALF_DIV(`RATE_SEL1_HZ);
  localparam integer H2_I = `HALF_DIV(`RATE_SEL2_HZ);
  localparam integer H3_I = `HALF_DIV(`RATE_SEL3_HZ);
  localparam [12:0] H0 = H0_I[12:0];
  localparam [12:0] H1 = H1_I[12:0];
  localparam [12:0] H2 = H2_I[12:0];
  localparam [12:0] H3 = H3_I[12:0];
  localparam [8:0]  E1 = 9'd1;
  localparam [8:0]  E4 = 9'd2;
  localparam [8:0]  E88 = 9'd44;
  localparam [8:0]  E352 = 9'd176;
  reg  [12:0] cnt_reg;
  reg  [8:0]  ecnt_reg;
  reg         ext_prev_reg;
  reg         phase_reg;
  reg  [12:0] half;
  reg  [8:0]  ehalf;
  wire        use_ext;
  wire        ext_edge;
  assign use_ext  = auto_mode && (serial_clk_select == `SEL_EXT); // RULE10
  assign ext_edge = ext_clk_inverted ? (ext_prev_reg && !ext_clk_in)
                                     : (!ext_prev_reg && ext_clk_in);
  always @* begin
    case (serial_clk_select) // RULE2 RULE24
      `SEL_EXT:  half = H0;
      `SEL_SLOW: half = H1;
      `SEL_MID:  half = H2;
      default:   half = H3;
    endcase
    case (ext_clk_divider)
      `EXT_DIV1:  ehalf = E1;
      `EXT_DIV4:  ehalf = E4;
      `EXT_DIV88: ehalf = E88;
      default:    ehalf = E352;
    endcase
  end
  // External mode: each half period is a count of active input edges; the first rise lands
  // on active edge ehalf (one edge later when undivided), with no extra lead-in below.
  always @(posedge core_clk) begin
    ext_prev_reg <= ext_clk_in;
    if (rst || !run) begin
      cnt_reg   <= 13'h0000;
      ecnt_reg  <= 9'h000;
      phase_reg <= 1'b0;
      rise_tick <= 1'b0;
      fall_tick <= 1'b0;
    end else if (use_ext) begin
      rise_tick <= 1'b0;
      fall_tick <= 1'b0;
      if (ext_edge) begin
        if (ecnt_reg + 9'd1 >= ehalf + ((ext_clk_divider == `EXT_DIV1) ? 9'd1 : 9'd0)) begin
          ecnt_reg  <= 9'h000;
          phase_reg <= !phase_reg;
          rise_tick <= !phase_reg; // RULE11 RULE12
          fall_tick <= phase_reg;
        end else begin
          ecnt_reg <= ecnt_reg + 9'd1;
        end
      end
    end else begin
      rise_tick <= 1'b0;
      fall_tick <= 1'b0;
      if (cnt_reg + 13'h0001 >= half) begin
        cnt_reg   <= 13'h0000;
        phase_reg <= !phase_reg;
        rise_tick <= !phase_reg;
        fall_tick <= phase_reg;
      end else begin
        cnt_reg <= cnt_reg + 13'h0001;
      end
    end
  end
endmodule

// File: verilog/serial_write_buffer.v
// Serial write buffer: automatic and interactive nibble shifter.
`timescale 1ns/1ps
`include "swb_consts.vh"
module serial_write_buffer (
  input  wire       core_clk,
  input  wire       rst,
  input  wire       serial_buf_enable,
  input  wire       port_is_output,
  input  wire [1:0] serial_clk_select,
  input  wire [1:0] ext_clk_divider,
  input  wire [1:0] last_nibble_clocks,
  input  wire       ext_clk_in,
  input  wire       ext_clk_inverted,
  input  wire       nibble_buffer_we,
  input  wire [3:0] nibble_buffer_wdata,
  input  wire       size_low_we,
  input  wire [3:0] size_low_wdata,
  input  wire       size_high_we,
  input  wire [3:0] size_high_wdata,
  input  wire       ram_we,
  input  wire [5:0] ram_waddr,
  input  wire [3:0] ram_wdata,
  input  wire       halt_request,
  input  wire       cpu_irq_enable,
  output reg        serial_clk_out,
  output reg        serial_data_out,
  output reg        cond_test_flag,
  output reg        buffer_empty_request,
  output reg        auto_send_select,
  output reg        interactive_start,
  output reg        cpu_standby,
  output reg        global_irq_enable,
  output reg  [3:0] nibble_buffer,
  output reg  [5:0] send_size
);
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_WAIT = 4'b0010;
  localparam [3:0] ST_SEND = 4'b0100;
  localparam [3:0] ST_DONE = 4'b1000;
  reg  [3:0] state_reg;
  reg  [3:0] ram [0:`RAM_WORDS-1];
  reg  [3:0] shift_reg;
  reg  [2:0] bits_left_reg;
  reg  [2:0] clocks_left_reg;
  reg  [5:0] addr_reg;
  reg        last_pkg_reg;
  reg        buf_full_reg;
  reg        sending_reg;
  wire       active;
  wire       rise_tick;
  wire       fall_tick;
  wire       halt_edge;
  reg        halt_prev_reg;
  reg        drop_reg;
  // Next values of the registers above and of the registered outputs.
  reg  [3:0] state_next;
  reg  [3:0] shift_next;
  reg  [2:0] bits_left_next;
  reg  [2:0] clocks_left_next;
  reg  [5:0] addr_next;
  reg        last_pkg_next;
  reg        buf_full_next;
  reg        sending_next;
  reg        drop_next;
  reg        clk_out_next;
  reg        data_out_next;
  reg        flag_next;
  reg        request_next;
  reg        auto_next;
  reg        start_next;
  reg        standby_next;
  reg  [3:0] buffer_next;
  reg  [5:0] size_next;
  assign active    = serial_buf_enable && port_is_output; // RULE1
  assign halt_edge = halt_request && !halt_prev_reg;

  function [2:0] last_clocks;
    input [1:0] code;
    begin
      last_clocks = 3'd4 - {1'b0, code}; // RULE8
    end
  endfunction

  function start_allowed;
    input [3:0] wdata;
    input       enabled;
    begin
      start_allowed = wdata[2] && !wdata[3] && enabled; // RULE18
    end
  endfunction

  function [5:0] next_addr;
    input [5:0] addr;
    reg   [6:0] sum;
    begin
      sum       = {1'b0, addr} + 7'h01;
      next_addr = sum[5:0];
    end
  endfunction

  function [2:0] pkg_clocks;
    input       is_last;
    input [1:0] code;
    begin
      if (is_last) begin
        pkg_clocks = last_clocks(code); // RULE7
      end else begin
        pkg_clocks = 3'h4;
      end
    end
  endfunction

  // An empty request is raised once the buffered nibble has moved into the shifter.
  function empty_due;
    input       started;
    input       shifting;
    input       auto_on;
    input       full;
    input       pending;
    input [2:0] bits_left;
    input       writing;
    begin
      empty_due = started && shifting && !auto_on && !full && !pending &&
                  (bits_left == 3'h4) && !writing;
    end
  endfunction

  swb_clk_gen clk_gen (
    .core_clk          (core_clk),
    .rst               (rst),
    .run               (sending_reg && active),
    .auto_mode         (auto_send_select),
    .serial_clk_select (serial_clk_select),
    .ext_clk_divider   (ext_clk_divider),
    .ext_clk_in        (ext_clk_in),
    .ext_clk_inverted  (ext_clk_inverted),
    .rise_tick         (rise_tick),
    .fall_tick         (fall_tick)
  );

  always @(posedge core_clk) begin
    if (ram_we) begin
      ram[ram_waddr] <= ram_wdata; // RULE13
    end
  end

  // Next-state logic for the shifter, its flags and the software-visible fields.
  always @* begin
    state_next       = state_reg;
    shift_next       = shift_reg;
    bits_left_next   = bits_left_reg;
    clocks_left_next = clocks_left_reg;
    addr_next        = addr_reg;
    last_pkg_next    = last_pkg_reg;
    buf_full_next    = buf_full_reg;
    sending_next     = sending_reg;
    drop_next        = 1'b0;
    clk_out_next     = serial_clk_out;
    data_out_next    = serial_data_out;
    flag_next        = cond_test_flag;
    request_next     = buffer_empty_request;
    auto_next        = auto_send_select;
    start_next       = interactive_start;
    standby_next     = cpu_standby;
    buffer_next      = nibble_buffer;
    size_next        = send_size;

    // Interactive data is released one cycle after the final falling clock.
    if (drop_reg) begin
      data_out_next = 1'b0; // RULE22
    end
    if (size_low_we) begin
      size_next[3:0] = size_low_wdata;
    end

    // An interactive start is refused with automatic mode or an idle block.
    if (size_high_we) begin
      size_next[5:4] = size_high_wdata[1:0]; // RULE14
      auto_next      = size_high_wdata[3];
      if (start_allowed(size_high_wdata, active)) begin
        start_next       = 1'b1;
        state_next       = ST_SEND;
        shift_next       = nibble_buffer; // RULE18
        bits_left_next   = 3'h4;
        clocks_left_next = 3'h4;
        buf_full_next    = 1'b0;
        sending_next     = 1'b1;
        data_out_next    = nibble_buffer[0];
      end
    end

    // Dropping enable or port direction stops the shifter and the lines.
    if (!active) begin
      sending_next  = 1'b0;
      clk_out_next  = 1'b0;
      data_out_next = 1'b0; // RULE9
      state_next    = ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          // The halt edge starts a send only when automatic mode was armed.
          if (auto_send_select && halt_edge) begin
            standby_next     = 1'b1; // RULE5
            state_next       = ST_SEND;
            sending_next     = 1'b1;
            shift_next       = nibble_buffer;
            bits_left_next   = 3'h4;
            clocks_left_next = 3'h4;
            addr_next        = 6'h00;
            last_pkg_next    = 1'b0;
          end
        end
        ST_SEND: begin
          if (rise_tick) begin
            // Clocks beyond the last-nibble count are swallowed while data still moves.
            clk_out_next  = (clocks_left_reg != 3'h0); // RULE7
            data_out_next = shift_reg[0]; // RULE3 RULE25
          end
          // Falling edge: move the next bit forward and count down the package.
          if (fall_tick) begin
            clk_out_next   = 1'b0;
            shift_next     = {1'b0, shift_reg[3:1]};
            bits_left_next = bits_left_reg - 3'h1;
            if (clocks_left_reg != 3'h0) begin
              clocks_left_next = clocks_left_reg - 3'h1;
            end
            if (bits_left_reg == 3'h1) begin
              // The RAM image follows the first nibble up to the sized address.
              if (auto_send_select) begin
                if (last_pkg_reg) begin
                  state_next   = ST_DONE;
                  sending_next = 1'b0;
                end else begin
                  shift_next       = ram[addr_reg]; // RULE13
                  last_pkg_next    = (addr_reg == send_size); // RULE14
                  addr_next        = next_addr(addr_reg);
                  clocks_left_next = pkg_clocks(addr_reg == send_size, last_nibble_clocks);
                  bits_left_next   = 3'h4;
                end
              end else if (buf_full_reg) begin
                shift_next       = nibble_buffer;
                buf_full_next    = 1'b0;
                bits_left_next   = 3'h4;
                clocks_left_next = 3'h4; // RULE22
                request_next     = 1'b1; // RULE21
                flag_next        = 1'b1;
              end else begin
                // Data drops a cycle later so it never moves with a falling clock.
                state_next   = ST_IDLE; // RULE19
                sending_next = 1'b0;
                start_next   = 1'b0;
                request_next = 1'b0;
                flag_next    = 1'b1;
                drop_next    = 1'b1;
              end
            end
          end
        end
        ST_DONE: begin
          // The last bit stays on the data line while the buffer is enabled.
          auto_next    = 1'b0; // RULE16
          flag_next    = 1'b1; // RULE6
          standby_next = 1'b0;
          state_next   = ST_IDLE;
        end
        default: state_next = ST_IDLE;
      endcase
    end

    // In interactive mode each nibble moved into the shifter asks software for the next one.
    if (empty_due(interactive_start, state_reg == ST_SEND, auto_send_select, buf_full_reg,
                  buffer_empty_request, bits_left_reg, nibble_buffer_we)) begin
      request_next = 1'b1; // RULE18
      flag_next    = 1'b1; // RULE4
    end

    // A buffer write wins over a request raised in the same cycle.
    if (nibble_buffer_we) begin
      buffer_next  = nibble_buffer_wdata;
      request_next = 1'b0; // RULE20
      flag_next    = 1'b0;
      if (interactive_start) begin
        buf_full_next = 1'b1;
      end
    end
  end

  // The CPU view of the interrupt enable is held off for the whole automatic send.
  always @(posedge core_clk) begin
    if (rst) begin
      halt_prev_reg     <= 1'b0;
      global_irq_enable <= 1'b0;
    end else begin
      halt_prev_reg     <= halt_request;
      global_irq_enable <= cpu_irq_enable && !auto_send_select; // RULE15 RULE17
    end
  end

  // Shifter state and package bookkeeping.
  always @(posedge core_clk) begin
    if (rst) begin
      state_reg       <= ST_IDLE;
      shift_reg       <= 4'h0;
      bits_left_reg   <= 3'h0;
      clocks_left_reg <= 3'h0;
      addr_reg        <= 6'h00;
      last_pkg_reg    <= 1'b0;
      buf_full_reg    <= 1'b0;
      sending_reg     <= 1'b0;
      drop_reg        <= 1'b0;
    end else begin
      state_reg       <= state_next;
      shift_reg       <= shift_next;
      bits_left_reg   <= bits_left_next;
      clocks_left_reg <= clocks_left_next;
      addr_reg        <= addr_next;
      last_pkg_reg    <= last_pkg_next;
      buf_full_reg    <= buf_full_next;
      sending_reg     <= sending_next;
      drop_reg        <= drop_next;
    end
  end

  // Registered outputs seen by the pins and by software.
  always @(posedge core_clk) begin
    if (rst) begin
      serial_clk_out       <= 1'b0;
      serial_data_out      <= 1'b0;
      cond_test_flag       <= 1'b0;
      buffer_empty_request <= 1'b0;
      auto_send_select     <= 1'b0;
      interactive_start    <= 1'b0;
      cpu_standby          <= 1'b0;
      nibble_buffer        <= `BUF_RESET;
      send_size            <= 6'h00;
    end else begin
      serial_clk_out       <= clk_out_next;
      serial_data_out      <= data_out_next;
      cond_test_flag       <= flag_next;
      buffer_empty_request <= request_next;
      auto_send_select     <= auto_next;
      interactive_start    <= start_next;
      cpu_standby          <= standby_next;
      nibble_buffer        <= buffer_next;
      send_size            <= size_next;
    end
  end
endmodule

// File: test/swb_receiver.sv
// Receiver model that samples serial data on the falling serial clock.
`timescale 1ns/1ps
module swb_receiver (
  input  wire         serial_clk_out,
  input  wire         serial_data_out,
  input  wire         clear,
  output logic [15:0] rx_bits,
  output int          rx_count
);
  always @(negedge serial_clk_out or posedge clear) begin
    if (clear) begin
      rx_bits <= 16'h0;
      rx_count <= 0;
    end else begin
      rx_bits[rx_count[3:0]] <= serial_data_out;
      rx_count <= rx_count + 1;
    end
  end
endmodule

// File: test/swb_monitor.sv
// Checker for the serial write buffer ports.
`timescale 1ns/1ps
module swb_monitor (
  input wire       core_clk,
  input wire       rst,
  input wire       serial_buf_enable,
  input wire       port_is_output,
  input wire [1:0] serial_clk_select,
  input wire       nibble_buffer_we,
  input wire       size_high_we,
  input wire       halt_request,
  input wire       serial_clk_out,
  input wire       serial_data_out,
  input wire       cond_test_flag,
  input wire       buffer_empty_request,
  input wire       auto_send_select,
  input wire       interactive_start,
  input wire       cpu_standby,
  input wire       global_irq_enable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_data_fall_stable: assert property ($fell(serial_clk_out) |-> $stable(serial_data_out))
    else $error("data moved at clock fall");
  a_irq_off_auto: assert property (auto_send_select |=> !global_irq_enable)
    else $error("interrupt enable during auto send");
  a_standby_no_irq: assert property (cpu_standby |-> !global_irq_enable)
    else $error("interrupt enable in standby");
  a_write_clears_flags: assert property (nibble_buffer_we |=> !buffer_empty_request && !cond_test_flag)
    else $error("buffer write left a flag set");
  a_inactive_no_clock: assert property (!(serial_buf_enable && port_is_output) |-> ##2 !serial_clk_out)
    else $error("clock while inactive");
  a_auto_end_flag: assert property ($fell(auto_send_select) && !$past(size_high_we) |-> ##[0:1] cond_test_flag)
    else $error("no finish flag");
  a_standby_exit: assert property ($fell(cpu_standby) |-> ##[0:2] (cond_test_flag && !auto_send_select))
    else $error("standby left without finish");
  a_halt_standby: assert property ($rose(halt_request) && auto_send_select |-> ##[1:2] cpu_standby)
    else $error("halt did not enter standby");
  a_underrun_stop: assert property ($fell(interactive_start) |-> ##[0:1] (!serial_clk_out && !buffer_empty_request))
    else $error("underrun left clock or request");
  a_fast_high_time: assert property ($rose(serial_clk_out) && serial_clk_select == 2'h3 |-> serial_clk_out[*8])
    else $error("fast clock high too short");
  c_auto_done: cover property ($fell(cpu_standby));
  c_empty_req: cover property ($rose(buffer_empty_request));
  c_underrun: cover property ($fell(interactive_start));
endmodule
bind serial_write_buffer swb_monitor i_mon (.core_clk, .rst, .serial_buf_enable, .port_is_output,
  .serial_clk_select, .nibble_buffer_we, .size_high_we, .halt_request, .serial_clk_out,
  .serial_data_out, .cond_test_flag, .buffer_empty_request, .auto_send_select,
  .interactive_start, .cpu_standby, .global_irq_enable);

// File: test/serial_write_buffer_tb.sv
// Self-checking bench for the serial write buffer.
`timescale 1ns/1ps
module serial_write_buffer_tb;
  logic core_clk = 0, rst = 1, clear = 1, seen, ext_clk_in = 0, ext_clk_inverted = 0;
  logic serial_buf_enable = 1, port_is_output = 1, halt_request = 0, cpu_irq_enable = 1;
  logic nibble_buffer_we = 0, size_low_we = 0, size_high_we = 0, ram_we = 0;
  logic [3:0] nibble_buffer_wdata = 0, size_low_wdata = 0, size_high_wdata = 0, ram_wdata = 0;
  logic [1:0] serial_clk_select = 2'h3, last_nibble_clocks = 2'h3, ext_clk_divider = 2'h0;
  logic [5:0] ram_waddr = 0, send_size;
  logic [3:0] nibble_buffer;
  logic serial_clk_out, serial_data_out, cond_test_flag, buffer_empty_request;
  logic auto_send_select, interactive_start, cpu_standby, global_irq_enable;
  logic [15:0] rx_bits;
  int rx_count, i, mismatches = 0, n_tests = 0;
  always #25 core_clk = ~core_clk;
  serial_write_buffer i_dut (.core_clk, .rst, .serial_buf_enable, .port_is_output,
    .serial_clk_select, .ext_clk_divider, .last_nibble_clocks, .ext_clk_in, .ext_clk_inverted,
    .nibble_buffer_we, .nibble_buffer_wdata, .size_low_we, .size_low_wdata, .size_high_we,
    .size_high_wdata, .ram_we, .ram_waddr, .ram_wdata, .halt_request, .cpu_irq_enable,
    .serial_clk_out, .serial_data_out, .cond_test_flag, .buffer_empty_request,
    .auto_send_select, .interactive_start, .cpu_standby, .global_irq_enable, .nibble_buffer,
    .send_size);
  swb_receiver i_rx (.serial_clk_out, .serial_data_out, .clear, .rx_bits, .rx_count);
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Kind 0 buffer, 1 size low, 2 size high, 3 RAM; one strobe cycle each.
  task wr(input int k, input logic [5:0] a, input logic [3:0] d);
    @(posedge core_clk);
    {nibble_buffer_wdata, size_low_wdata, size_high_wdata, ram_wdata} <= {4{d}};
    ram_waddr <= a;
    {nibble_buffer_we, size_low_we, size_high_we, ram_we} <= 4'h8 >> k;
    @(posedge core_clk);
    {nibble_buffer_we, size_low_we, size_high_we, ram_we} <= 4'h0;
  endtask
  task clr_rx;
    @(posedge core_clk) clear <= 1;
    @(posedge core_clk) clear <= 0;
  endtask
  task t_disabled;
    clr_rx;
    @(posedge core_clk) port_is_output <= 0;
    wr(0, 0, 4'h9);
    wr(2, 0, 4'h4);
    repeat (300) @(posedge core_clk);
    chk(16'(rx_count), 16'h0);
    chk(interactive_start, 16'h0);
    @(posedge core_clk) port_is_output <= 1;
  endtask
  // The second pass resends the same data by rewriting buffer and size.
  task t_auto;
    repeat (2) begin
      clr_rx;
      wr(0, 0, 4'h5);
      wr(3, 0, 4'hA);
      wr(1, 0, 4'h0);
      wr(2, 0, 4'h8);
      @(posedge core_clk) halt_request <= 1;
      for (i = 0; i < 3000 && cpu_standby !== 1'b1; i++) @(posedge core_clk);
      for (i = 0; i < 3000 && cpu_standby !== 1'b0; i++) @(posedge core_clk);
      halt_request <= 0;
      repeat (4) @(posedge core_clk);
      #1;
      chk(16'(rx_count), 16'h5);
      chk(rx_bits[4:0], 16'h5);
      chk({serial_data_out, cond_test_flag, auto_send_select, global_irq_enable}, 16'hD);
      wr(0, 0, 4'h0);
      #1;
      chk(cond_test_flag, 16'h0);
    end
  endtask
  task t_inter;
    clr_rx;
    seen = 0;
    wr(0, 0, 4'h6);
    wr(2, 0, 4'h4);
    for (i = 0; i < 3000 && (i < 3 || interactive_start !== 1'b0); i++) begin
      @(posedge core_clk);
      seen |= buffer_empty_request;
    end
    #1;
    chk({seen, interactive_start, buffer_empty_request, cond_test_flag, serial_clk_out}, 16'h12);
    chk(16'(rx_count), 16'h4);
    chk(rx_bits[3:0], 16'h6);
    wr(0, 0, 4'h0);
  endtask
  task tally_and_finish;
    if (mismatches == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    #1;
    chk({nibble_buffer, send_size, cond_test_flag, buffer_empty_request, auto_send_select,
      interactive_start, cpu_standby, global_irq_enable}, 16'hF000);
    @(posedge core_clk);
    rst <= 0;
    clear <= 0;
    t_disabled;
    t_auto;
    t_inter;
    tally_and_finish;
  end
  initial begin
    #2000000;
    mismatches++;
    tally_and_finish;
  end
endmodule
